// [design/attr_pkg.sv]
// Purpose: shared constants and types for the transfer attribute decoder pair
// Assumes: seven-bit protection attribute travels with the address phase
// Notes:   bit positions, reset values and type codes live here; checker and test repeat some as literals
package attr_pkg;

  localparam int unsigned ATTR_W     = 7;
  localparam int unsigned BIT_DATA   = 0;
  localparam int unsigned BIT_PRIV   = 1;
  localparam int unsigned BIT_BUF    = 2;
  localparam int unsigned BIT_MOD    = 3;
  localparam int unsigned BIT_LOOKUP = 4;
  localparam int unsigned BIT_ALLOC  = 5;
  localparam int unsigned BIT_SHARE  = 6;

  // Safe value for a manager without accurate knowledge: privileged data
  localparam logic [6:0] ATTR_RST     = 7'h03;
  // Legacy four-bit form with extended types off: Device-nE privileged data
  localparam logic [6:0] ATTR_DEFAULT = 7'h03;

  typedef enum logic [2:0] {
    MT_DEV_NE = 3'h0,
    MT_DEV_E  = 3'h1,
    MT_NORM_NC = 3'h2,
    MT_WT     = 3'h3,
    MT_WB     = 3'h4,
    MT_ILLEGAL = 3'h7
  } mem_type_e;

  typedef logic [ATTR_W-1:0] attr_t;

endpackage

// [design/attr_if.sv]
// Purpose: address-phase attribute carrier between manager and subordinate
// Assumes: single clock, attribute sampled with a valid address phase
// Notes:   one modport for each end
`timescale 1ns/1ps
`default_nettype none
interface attr_if;
  logic              valid;
  logic [6:0]        prot;
  logic              burst_cont;
  modport mgr (output valid, output prot, output burst_cont);
  modport sub (input valid, input prot, input burst_cont);
endinterface
`default_nettype wire

// [design/attr_manager.sv]
// Purpose: manager end that drives the protection attribute per transfer
// Assumes: user side presents one request per cycle with its fields
// Notes:   attribute is frozen across every beat of a burst
`timescale 1ns/1ps
`default_nettype none
module attr_manager (
  // Clock and reset
  input  wire logic       REF_CLK,
  input  wire logic       RSTN,
  // User request
  input  wire logic       REQ_VALID,
  input  wire logic       REQ_SEQ,
  input  wire logic       REQ_IS_INST,
  input  wire logic       REQ_PRIV,
  input  wire logic [4:0] REQ_TYPE_BITS,
  input  wire logic       EXT_TYPES,
  // Bus side
  attr_if.mgr             bus
);

  typedef struct packed {
    logic       valid;
    logic [6:0] prot;
    logic       seq;
  } mstate_s;

  mstate_s s_q;
  mstate_s s_d;

  always_comb begin
    s_d       = s_q;
    s_d.valid = REQ_VALID;
    s_d.seq   = REQ_VALID && REQ_SEQ;
    if (REQ_VALID && !REQ_SEQ) begin
      // Data unless known to be a fetch
      s_d.prot[attr_pkg::BIT_DATA] = !REQ_IS_INST;
      s_d.prot[attr_pkg::BIT_PRIV] = REQ_PRIV;
      if (EXT_TYPES) begin
        s_d.prot[6:2] = REQ_TYPE_BITS;
        // Device memory: shareable and allocate forced low
        if (REQ_TYPE_BITS[2:1] == 2'h0) begin
          s_d.prot[attr_pkg::BIT_SHARE] = 1'b0;
          s_d.prot[attr_pkg::BIT_ALLOC] = 1'b0;
        end
        // Never drive allocate without lookup
        if (!REQ_TYPE_BITS[2]) begin
          s_d.prot[attr_pkg::BIT_ALLOC] = 1'b0;
        end
        // Lookup without modifiable, or buffered non-cacheable normal: fall back
        if ((REQ_TYPE_BITS[2] && !REQ_TYPE_BITS[1]) ||
            (REQ_TYPE_BITS[1] && !REQ_TYPE_BITS[2] && REQ_TYPE_BITS[0])) begin
          s_d.prot[6:2] = 5'h00;
        end
      end else begin
        s_d.prot[6:4] = 3'h0;
        s_d.prot[3:2] = REQ_TYPE_BITS[1:0];
      end
    end
    // Burst beats keep the attribute of the first beat
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      s_q <= '{valid: 1'b0, prot: attr_pkg::ATTR_RST, seq: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.valid      = s_q.valid;
  assign bus.prot       = s_q.prot;
  assign bus.burst_cont = s_q.seq;

endmodule // attr_manager
`default_nettype wire

// [design/attr_decoder.sv]
// Purpose: subordinate end that classifies and checks the protection attribute
// Assumes: attribute valid in the cycle that valid is high
// Notes:   all outputs registered, one cycle after the address phase
`timescale 1ns/1ps
`default_nettype none
module attr_decoder (
  // Clock and reset
  input  wire logic       REF_CLK,
  input  wire logic       RSTN,
  // Property strap
  input  wire logic       EXT_TYPES,
  // Bus side
  attr_if.sub             bus,
  // Decoded attribute
  output logic            XFER_VALID,
  output logic            IS_DATA,
  output logic            IS_PRIV,
  output logic [2:0]      MEM_TYPE,
  output logic            SHAREABLE,
  output logic            ALLOC_HINT,
  output logic            EARLY_RESP_OK,
  output logic            MAY_MODIFY,
  output logic            NEED_LOOKUP,
  output logic            WAIT_VISIBLE,
  output logic            ATTR_ERR,
  output logic            BURST_ERR
);

  typedef struct packed {
    logic       vld;
    logic       data;
    logic       priv;
    logic [2:0] mtype;
    logic       share;
    logic       alloc;
    logic       early;
    logic       modify;
    logic       lookup;
    logic       visible;
    logic       err;
    logic       berr;
    logic [6:0] held;
  } dstate_s;

  dstate_s s_q;
  dstate_s s_d;

  // Idle values; data and privilege follow the safe manager attribute
  localparam dstate_s RST_STATE = '{
    vld:     1'b0,
    data:    attr_pkg::ATTR_RST[attr_pkg::BIT_DATA],
    priv:    attr_pkg::ATTR_RST[attr_pkg::BIT_PRIV],
    mtype:   attr_pkg::MT_DEV_NE,
    share:   1'b0,
    alloc:   1'b0,
    early:   1'b0,
    modify:  1'b0,
    lookup:  1'b0,
    visible: 1'b0,
    err:     1'b0,
    berr:    1'b0,
    held:    attr_pkg::ATTR_RST
  };

  // Permitted rows of bits 6..2 as value and care mask; shareable is a
  // don't-care on the Device rows because receivers ignore it there
  localparam int unsigned N_ROWS = 5;
  localparam logic [4:0] ROW_VAL [N_ROWS] = '{
    5'h00, // Device-nE
    5'h01, // Device-E
    5'h02, // Normal Non-cacheable
    5'h06, // Write-through
    5'h07  // Write-back
  };
  localparam logic [4:0] ROW_CARE [N_ROWS] = '{
    5'h0F, 5'h0F, 5'h0F, 5'h07, 5'h07
  };

  // Classify bits 6..2 into a memory type
  function automatic attr_pkg::mem_type_e classify(input logic [4:0] t);
    attr_pkg::mem_type_e m;
    m = attr_pkg::MT_ILLEGAL;
    unique casez (t)
      5'b?0000: m = attr_pkg::MT_DEV_NE;
      5'b?0001: m = attr_pkg::MT_DEV_E;
      5'b?0010: m = attr_pkg::MT_NORM_NC;
      5'b??110: m = attr_pkg::MT_WT;
      5'b??111: m = attr_pkg::MT_WB;
      default:  m = attr_pkg::MT_ILLEGAL;
    endcase
    return m;
  endfunction

  // Table walk kept apart from classify, so a slip in one shows up
  function automatic logic permitted(input logic [4:0] t);
    logic hit;
    hit = 1'b0;
    for (int r = 0; r < N_ROWS; r++) begin
      hit = hit | ((t & ROW_CARE[r]) == ROW_VAL[r]);
    end
    return hit;
  endfunction

  // Four-bit form: a modifiable transfer stands for a cached one
  function automatic logic legacy_cached(input logic ext, input logic modifiable);
    return !ext && modifiable;
  endfunction

  function automatic logic is_device(input attr_pkg::mem_type_e m);
    return (m == attr_pkg::MT_DEV_NE) || (m == attr_pkg::MT_DEV_E);
  endfunction

  // Write-through stays strict even though a cache could answer early
  function automatic logic early_ok(input logic bufferable, input attr_pkg::mem_type_e m);
    return bufferable &&
           (m != attr_pkg::MT_DEV_NE) && (m != attr_pkg::MT_NORM_NC);
  endfunction

  logic [6:0]          eff;
  attr_pkg::mem_type_e mt;
  logic                is_dev;
  logic                cached;
  logic                f_data;
  logic                f_priv;
  logic                f_buf;
  logic                f_mod;
  logic                f_look;
  logic                f_alloc;
  logic                f_share;

  always_comb begin
    // Without the property the upper bits are not carried
    eff     = EXT_TYPES ? bus.prot : {3'h0, bus.prot[3:0]};
    f_data  = eff[attr_pkg::BIT_DATA];
    f_priv  = eff[attr_pkg::BIT_PRIV];
    f_buf   = eff[attr_pkg::BIT_BUF];
    f_mod   = eff[attr_pkg::BIT_MOD];
    f_look  = eff[attr_pkg::BIT_LOOKUP];
    f_alloc = eff[attr_pkg::BIT_ALLOC];
    f_share = eff[attr_pkg::BIT_SHARE];
    cached  = legacy_cached(EXT_TYPES, f_mod);
    mt      = classify(eff[6:2]);
    // Legacy four-bit form cannot name lookup, so map it
    if (cached) begin
      mt = f_buf ? attr_pkg::MT_WB : attr_pkg::MT_WT;
    end
    is_dev = is_device(mt);

    s_d      = s_q;
    s_d.vld  = bus.valid;
    s_d.berr = 1'b0;
    s_d.err  = 1'b0;
    if (bus.valid) begin
      s_d.data  = f_data;
      s_d.priv  = f_priv;
      s_d.mtype = mt;
      // Shareable ignored for Device
      s_d.share   = f_share && !is_dev;
      s_d.visible = f_share && !is_dev;
      s_d.alloc   = f_alloc && !is_dev;
      s_d.early   = early_ok(f_buf, mt);
      s_d.modify  = f_mod;
      s_d.lookup  = f_look || cached;
      // Only the extended form can carry an illegal row
      s_d.err     = EXT_TYPES && !permitted(eff[6:2]);
      // A burst beat must carry the previous valid beat's attribute
      s_d.berr    = bus.burst_cont && (bus.prot != s_q.held);
      s_d.held    = bus.prot;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      s_q <= RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  assign XFER_VALID    = s_q.vld;
  assign IS_DATA       = s_q.data;
  assign IS_PRIV       = s_q.priv;
  assign MEM_TYPE      = s_q.mtype;
  assign SHAREABLE     = s_q.share;
  assign ALLOC_HINT    = s_q.alloc;
  assign EARLY_RESP_OK = s_q.early;
  assign MAY_MODIFY    = s_q.modify;
  assign NEED_LOOKUP   = s_q.lookup;
  assign WAIT_VISIBLE  = s_q.visible;
  assign ATTR_ERR      = s_q.err;
  assign BURST_ERR     = s_q.berr;

endmodule // attr_decoder
`default_nettype wire

// [tb/attr_checker.sv]
// Purpose: wire and decode checks beside the attribute carrier
// Assumes: one clock, sync active-low reset
// Notes: manager sanitises, so no illegal value should reach the wire
`timescale 1ns/1ps
`default_nettype none
module attr_checker (
  // Clock and reset
  input wire logic       REF_CLK,
  input wire logic       RSTN,
  // Carrier and decode
  input wire logic       EXT_TYPES,
  input wire logic       valid,
  input wire logic [6:0] prot,
  input wire logic       burst_cont,
  input wire logic       XFER_VALID,
  input wire logic [2:0] MEM_TYPE,
  input wire logic       EARLY_RESP_OK,
  input wire logic       WAIT_VISIBLE,
  input wire logic       ATTR_ERR
);
  logic [6:0] held_q;
  logic       ok;
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) held_q <= 7'h03;
    else if (valid && !burst_cont) held_q <= prot;
  end
  assign ok = (prot[6:3] == 4'h0) || (prot[5:2] == 4'h2) || (prot[4:3] == 2'h3);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  dev_zero_a: assert property (EXT_TYPES && valid && prot[4:3] == 2'h0 |-> prot[6:5] == 2'h0)
    else $error("device attribute with share or alloc set");
  legal_attr_a: assert property (EXT_TYPES && valid |-> ok)
    else $error("illegal attribute on the wire");
  burst_hold_a: assert property (valid && burst_cont |-> prot == held_q)
    else $error("attribute changed inside a burst");
  xfer_follow_a: assert property (XFER_VALID == $past(valid))
    else $error("decode strobe not one cycle after address phase");
  wb_type_a: assert property (valid && prot[4:2] == 3'h7 |=> MEM_TYPE == 3'h4)
    else $error("write-back not decoded");
  dev_e_a: assert property (valid && prot[4:2] == 3'h1 |=> MEM_TYPE == 3'h1)
    else $error("early-response device not decoded");
  norm_nc_a: assert property (EXT_TYPES && valid && prot[4:2] == 3'h2 |=> ##0 MEM_TYPE == 3'h2)
    else $error("non-cacheable not decoded");
  no_err_a: assert property (valid && ok |=> !ATTR_ERR)
    else $error("error flag on a legal attribute");
  dev_no_early_a: assert property (valid && prot[4:2] == 3'h0 |=> !EARLY_RESP_OK)
    else $error("early response allowed for strict device");
  share_wait_a: assert property (EXT_TYPES && valid && prot[6] && prot[3] |=> WAIT_VISIBLE)
    else $error("shareable normal transfer not held for visibility");
  cover property (valid && burst_cont);
  cover property (valid && prot[4:2] == 3'h7);
  cover property (valid && prot[4:3] == 2'h0);
endmodule // attr_checker
`default_nettype wire

// [tb/bus_memory_attribute_decoder_test.sv]
// Purpose: end-to-end test of manager and decoder across the carrier
// Assumes: one request in flight at a time
// Notes: full sweep of type bits, then random bursts
`timescale 1ns/1ps
`default_nettype none
module bus_memory_attribute_decoder_test;
  logic REF_CLK = 0, RSTN = 0, REQ_VALID = 0, REQ_SEQ = 0, REQ_IS_INST = 0, REQ_PRIV = 0;
  logic EXT_TYPES = 0, l_inst = 0, l_priv = 0;
  logic [4:0] REQ_TYPE_BITS = 5'h00, l_t = 5'h00;
  logic XFER_VALID, IS_DATA, IS_PRIV, SHAREABLE, ALLOC_HINT, EARLY_RESP_OK;
  logic MAY_MODIFY, NEED_LOOKUP, WAIT_VISIBLE, ATTR_ERR, BURST_ERR;
  logic [2:0] MEM_TYPE;
  int fails = 0, compares = 0;
  attr_if bus_if();
  attr_manager attr_manager_inst(.REF_CLK, .RSTN, .REQ_VALID, .REQ_SEQ, .REQ_IS_INST,
    .REQ_PRIV, .REQ_TYPE_BITS, .EXT_TYPES, .bus(bus_if.mgr));
  attr_decoder attr_decoder_inst(.REF_CLK, .RSTN, .EXT_TYPES, .bus(bus_if.sub), .XFER_VALID,
    .IS_DATA, .IS_PRIV, .MEM_TYPE, .SHAREABLE, .ALLOC_HINT, .EARLY_RESP_OK, .MAY_MODIFY,
    .NEED_LOOKUP, .WAIT_VISIBLE, .ATTR_ERR, .BURST_ERR);
  attr_checker attr_checker_inst(.REF_CLK, .RSTN, .EXT_TYPES, .valid(bus_if.valid),
    .prot(bus_if.prot), .burst_cont(bus_if.burst_cont), .XFER_VALID, .MEM_TYPE, .EARLY_RESP_OK,
    .WAIT_VISIBLE, .ATTR_ERR);
  always #20 REF_CLK = ~REF_CLK;
  function automatic logic [2:0] exp_type(input logic ext, input logic [4:0] t);
    if (!t[1] && !(ext && t[2])) return t[0] ? 3'h1 : 3'h0;
    if (!t[1] || (ext && !t[2] && t[0])) return 3'h0;
    if (ext && !t[2]) return 3'h2;
    return t[0] ? 3'h4 : 3'h3;
  endfunction
  task automatic check(input string what, input logic [2:0] seen, input logic [2:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic send(input logic seq, input logic ext, input logic [4:0] t, input logic [2:0] mt);
    int n;
    @(negedge REF_CLK);
    {REQ_VALID, REQ_SEQ, EXT_TYPES, REQ_TYPE_BITS} = {1'b1, seq, ext, t};
    {REQ_IS_INST, REQ_PRIV} = 2'($urandom);
    if (!seq) {l_inst, l_priv, l_t} = {REQ_IS_INST, REQ_PRIV, t};
    @(negedge REF_CLK);
    REQ_VALID = 0;
    for (n = 0; n < 8 && XFER_VALID !== 1'b1; n++) @(negedge REF_CLK);
    if (n == 8) begin
      fails++;
      finish_test();
    end
    check("type", MEM_TYPE, mt);
    check("data", 3'(IS_DATA), 3'(!l_inst));
    check("priv", 3'(IS_PRIV), 3'(l_priv));
    check("early", 3'(EARLY_RESP_OK), 3'(mt == 3'h1 || mt == 3'h4));
    check("share", 3'(SHAREABLE), 3'(ext && l_t[4] && mt >= 3'h2));
    check("alloc", 3'(ALLOC_HINT), 3'(ext && l_t[3] && mt >= 3'h3));
    check("visible", 3'(WAIT_VISIBLE), 3'(ext && l_t[4] && mt >= 3'h2));
    check("lookup", 3'(NEED_LOOKUP), 3'(mt == 3'h3 || mt == 3'h4));
    check("modify", 3'(MAY_MODIFY), 3'(mt inside {3'h2, 3'h3, 3'h4}));
    check("errs", {1'b0, ATTR_ERR, BURST_ERR}, 3'h0);
  endtask
  initial begin
    logic [4:0] t;
    logic ext;
    void'($urandom(6));
    repeat (8) @(negedge REF_CLK);
    RSTN = 1;
    check("rst", {MEM_TYPE[0], IS_DATA, IS_PRIV}, 3'h3);
    for (int i = 0; i < 64; i++) send(0, i[5], i[4:0], exp_type(i[5], i[4:0]));
    for (int i = 0; i < 100; i++) begin
      {ext, t} = 6'($urandom);
      send(0, ext, t, exp_type(ext, t));
      repeat ($urandom_range(0, 3)) send(1, ext, 5'($urandom), exp_type(ext, t));
    end
    finish_test();
  end
endmodule // bus_memory_attribute_decoder_test
`default_nettype wire
